/* File: ptp_cap_mem.sv */
`timescale 1ns/1ps
module ptp_cap_mem #(
    parameter int depth = 16,
    parameter int width = 64
) (
    // clock
    input wire logic clock,
    // write port
    input wire logic wr_en,
    input wire logic [$clog2(depth)-1:0] wr_addr,
    input wire logic [width-1:0] wr_data,
    // read port
    input wire logic [$clog2(depth)-1:0] rd_addr,
    output logic [width-1:0] rd_data
);
    logic [width-1:0] mem [depth];

    always_ff @(posedge clock) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock) begin
        rd_data <= mem[rd_addr];
    end
endmodule

/* File: ptp_clock_command_control.sv */
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - target read command copies both compare targets A and B into readable registers
// - four-bit capture select resets to zero; top bit falling edge, low bits GPIO
// - capture select addresses all sixteen capture register sets, both edges of eight GPIOs
// - manual capture stores present clock into the selected capture set
// - manual capture also sets the matching interrupt status bit
// - temporary rate command runs clock at temp rate for duration, then normal
// - nanosecond step command adds step amount to clock nanoseconds
// - seconds step command adds or subtracts step amount per direction bit
// - clock load command loads holding registers into running clock
// - clock read command latches running clock into holding registers
// - writing one enables unit; read returns enabled state; zero does nothing
// - enable bit after reset takes the configuration strap value
// - disable blocks new frames, clears enable once busy frames finish
// - unit reset clears timestamp hardware, disables unit, aborts frame work
// - command bits other than enable write-only, self-clearing, read zero; zero writes ignored
module ptp_clock_command_control import ptp_cmd_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic srst,
    // strap
    input wire logic enable_strap,
    // axi4-lite write
    input wire logic [11:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [11:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // running clock and targets
    input wire logic [31:0] run_seconds,
    input wire logic [29:0] run_nanoseconds,
    input wire logic [31:0] run_subnanoseconds,
    input wire logic [31:0] target_a_seconds,
    input wire logic [29:0] target_a_nanoseconds,
    input wire logic [31:0] target_b_seconds,
    input wire logic [29:0] target_b_nanoseconds,
    // frame engine
    input wire logic frame_busy,
    output logic frame_start_allow,
    output logic unit_enabled,
    output logic unit_reset_pulse,
    // clock update
    output logic load_pulse,
    output logic [31:0] load_seconds,
    output logic [29:0] load_nanoseconds,
    output logic [31:0] load_subnanoseconds,
    output logic temp_rate_active,
    output logic [31:0] temp_rate_value,
    // interrupt
    output logic irq
);
    //------------------------------------------------------------
    // bus slave
    //------------------------------------------------------------
    logic aw_held_q, w_held_q;
    logic [11:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic wr_fire;
    logic rd_pend_q;
    logic [11:0] rd_addr_q;

    assign wr_fire = aw_held_q && w_held_q && !bvalid;

    always_ff @(posedge clock) begin
        if (srst) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= resp_okay;
        end else begin
            awready <= 1'b0;
            wready <= 1'b0;
            if (awvalid && !aw_held_q && !awready) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= awaddr;
                awready <= 1'b1;
            end
            if (wvalid && !w_held_q && !wready) begin
                w_held_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
                wready <= 1'b1;
            end
            if (wr_fire) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wr_known(aw_addr_q) ? resp_okay : resp_slverr;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    function automatic logic wr_known(input logic [11:0] a);
        return a == addr_cmd_ctl || a == addr_int_en || a == addr_int_clr ||
            a == addr_clock_sec || a == addr_clock_ns || a == addr_clock_subns ||
            a == addr_temp_rate || a == addr_temp_dur || a == addr_step_adj;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
            input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // write strobe for the command register only, only full-byte lanes touched
    logic [31:0] wcmd;
    assign wcmd = (wr_fire && aw_addr_q == addr_cmd_ctl) ? merge(32'h0, w_data_q, w_strb_q)
        : 32'h00000000;

    //------------------------------------------------------------
    // software registers
    //------------------------------------------------------------
    logic [3:0] cap_sel_q;
    logic [31:0] sec_hold_q, subns_hold_q, temp_rate_q, temp_dur_q, step_q;
    logic [29:0] ns_hold_q;
    logic [31:0] tgt_a_sec_q, tgt_b_sec_q;
    logic [29:0] tgt_a_ns_q, tgt_b_ns_q;
    logic [irq_width-1:0] irq_sts_q, irq_en_q, irq_set;
    logic unit_rst;

    assign unit_rst = wcmd[bit_reset];

    logic [31:0] en_merged, ns_merged;
    assign en_merged = merge({16'h0000, irq_en_q}, w_data_q, w_strb_q);
    assign ns_merged = merge({2'b00, ns_hold_q}, w_data_q, w_strb_q);

    always_ff @(posedge clock) begin
        if (srst || unit_rst) begin
            cap_sel_q <= sel_reset;
            temp_rate_q <= 32'h00000000;
            temp_dur_q <= 32'h00000000;
            step_q <= 32'h00000000;
            irq_en_q <= '0;
        end else if (wr_fire) begin
            if (aw_addr_q == addr_cmd_ctl && w_strb_q[1]) begin
                cap_sel_q <= w_data_q[sel_hi:sel_lo];
            end
            if (aw_addr_q == addr_temp_rate) begin
                temp_rate_q <= merge(temp_rate_q, w_data_q, w_strb_q);
            end
            if (aw_addr_q == addr_temp_dur) begin
                temp_dur_q <= merge(temp_dur_q, w_data_q, w_strb_q);
            end
            if (aw_addr_q == addr_step_adj) begin
                step_q <= merge(step_q, w_data_q, w_strb_q);
            end
            if (aw_addr_q == addr_int_en) begin
                irq_en_q <= en_merged[irq_width-1:0];
            end
        end
    end

    // holding registers: software writes, or clock read snapshot in one cycle
    always_ff @(posedge clock) begin
        if (srst || unit_rst) begin
            sec_hold_q <= 32'h00000000;
            ns_hold_q <= 30'h00000000;
            subns_hold_q <= 32'h00000000;
        end else if (wcmd[bit_clock_read]) begin
            sec_hold_q <= run_seconds;
            ns_hold_q <= run_nanoseconds;
            subns_hold_q <= run_subnanoseconds;
        end else if (wr_fire) begin
            if (aw_addr_q == addr_clock_sec) begin
                sec_hold_q <= merge(sec_hold_q, w_data_q, w_strb_q);
            end
            if (aw_addr_q == addr_clock_ns) begin
                ns_hold_q <= ns_merged[29:0];
            end
            if (aw_addr_q == addr_clock_subns) begin
                subns_hold_q <= merge(subns_hold_q, w_data_q, w_strb_q);
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst || unit_rst) begin
            tgt_a_sec_q <= 32'h00000000;
            tgt_a_ns_q <= 30'h00000000;
            tgt_b_sec_q <= 32'h00000000;
            tgt_b_ns_q <= 30'h00000000;
        end else if (wcmd[bit_target_read]) begin
            tgt_a_sec_q <= target_a_seconds;
            tgt_a_ns_q <= target_a_nanoseconds;
            tgt_b_sec_q <= target_b_seconds;
            tgt_b_ns_q <= target_b_nanoseconds;
        end
    end

    //------------------------------------------------------------
    // clock update commands
    //------------------------------------------------------------
    logic [31:0] step_amt;
    logic [31:0] ns_sum;
    assign step_amt = {2'b00, step_q[step_val_hi:0]};
    assign ns_sum = {2'b00, run_nanoseconds} + step_amt;

    always_ff @(posedge clock) begin
        if (srst || unit_rst) begin
            load_pulse <= 1'b0;
            load_seconds <= 32'h00000000;
            load_nanoseconds <= 30'h00000000;
            load_subnanoseconds <= 32'h00000000;
        end else begin
            load_pulse <= 1'b0;
            if (wcmd[bit_clock_load]) begin
                load_pulse <= 1'b1;
                load_seconds <= sec_hold_q;
                load_nanoseconds <= ns_hold_q;
                load_subnanoseconds <= subns_hold_q;
            end else if (wcmd[bit_step_ns]) begin
                load_pulse <= 1'b1;
                load_subnanoseconds <= run_subnanoseconds;
                if (ns_sum >= ns_per_sec) begin
                    load_seconds <= run_seconds + 32'h00000001;
                    load_nanoseconds <= 30'(ns_sum - ns_per_sec);
                end else begin
                    load_seconds <= run_seconds;
                    load_nanoseconds <= ns_sum[29:0];
                end
            end else if (wcmd[bit_step_sec]) begin
                load_pulse <= 1'b1;
                load_seconds <= step_q[step_dir_bit] ? run_seconds - step_amt
                    : run_seconds + step_amt;
                load_nanoseconds <= run_nanoseconds;
                load_subnanoseconds <= run_subnanoseconds;
            end
        end
    end

    // temporary rate window counted in clock cycles
    logic [31:0] temp_left_q;
    always_ff @(posedge clock) begin
        if (srst || unit_rst) begin
            temp_rate_active <= 1'b0;
            temp_left_q <= 32'h00000000;
            temp_rate_value <= 32'h00000000;
        end else if (wcmd[bit_temp_rate]) begin
            temp_rate_active <= temp_dur_q != 32'h00000000;
            temp_left_q <= temp_dur_q;
            temp_rate_value <= temp_rate_q;
        end else if (temp_rate_active) begin
            temp_left_q <= temp_left_q - 32'h00000001;
            if (temp_left_q == 32'h00000001) begin
                temp_rate_active <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // manual capture
    //------------------------------------------------------------
    logic [63:0] cap_rd;
    logic cap_we;
    assign cap_we = wcmd[bit_manual_cap];
    logic [3:0] cap_sel_wr;
    // the selector written alongside the capture bit picks the destination
    assign cap_sel_wr = w_data_q[sel_hi:sel_lo];

    ptp_cap_mem #(.depth(2 * gpio_count), .width(64)) cap_mem (
        .clock(clock),
        .wr_en(cap_we),
        .wr_addr(cap_sel_wr),
        .wr_data({run_seconds, 2'b00, run_nanoseconds}),
        .rd_addr(araddr[6:3]),
        .rd_data(cap_rd)
    );

    always_comb begin
        irq_set = '0;
        if (cap_we) begin
            irq_set[cap_sel_wr] = 1'b1;
        end
    end

    //------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------
    logic [irq_width-1:0] irq_clr;
    logic [31:0] clr_merged;
    assign clr_merged = merge(32'h0, w_data_q, w_strb_q);
    assign irq_clr = (wr_fire && aw_addr_q == addr_int_clr) ?
        clr_merged[irq_width-1:0] : '0;

    always_ff @(posedge clock) begin
        if (srst || unit_rst) begin
            irq_sts_q <= '0;
            irq <= 1'b0;
        end else begin
            irq_sts_q <= (irq_sts_q & ~irq_clr) | irq_set;
            irq <= |(((irq_sts_q & ~irq_clr) | irq_set) & irq_en_q);
        end
    end

    //------------------------------------------------------------
    // enable, disable, reset
    //------------------------------------------------------------
    logic strap_load_q, dis_pend_q;
    always_ff @(posedge clock) begin
        if (srst) begin
            strap_load_q <= 1'b1;
            unit_enabled <= 1'b0;
            dis_pend_q <= 1'b0;
            frame_start_allow <= 1'b0;
            unit_reset_pulse <= 1'b0;
        end else begin
            strap_load_q <= 1'b0;
            unit_reset_pulse <= unit_rst;
            if (strap_load_q) begin
                unit_enabled <= enable_strap;
                frame_start_allow <= enable_strap;
            end else if (unit_rst) begin
                unit_enabled <= 1'b0;
                dis_pend_q <= 1'b0;
                frame_start_allow <= 1'b0;
            end else if (wcmd[bit_disable] || dis_pend_q) begin
                dis_pend_q <= frame_busy;
                frame_start_allow <= 1'b0;
                if (!frame_busy) begin
                    unit_enabled <= 1'b0;
                end
            end else if (wcmd[bit_enable]) begin
                unit_enabled <= 1'b1;
                frame_start_allow <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // read channel
    //------------------------------------------------------------
    function automatic logic [32:0] rd_mux(input logic [11:0] a);
        case (a)
            addr_cmd_ctl: rd_mux = {1'b1, 19'h0, cap_sel_q, 6'h00, unit_enabled, 2'b00};
            addr_int_sts: rd_mux = {1'b1, 16'h0000, irq_sts_q};
            addr_int_en: rd_mux = {1'b1, 16'h0000, irq_en_q};
            addr_clock_sec: rd_mux = {1'b1, sec_hold_q};
            addr_clock_ns: rd_mux = {1'b1, 2'b00, ns_hold_q};
            addr_clock_subns: rd_mux = {1'b1, subns_hold_q};
            addr_temp_rate: rd_mux = {1'b1, temp_rate_q};
            addr_temp_dur: rd_mux = {1'b1, temp_dur_q};
            addr_step_adj: rd_mux = {1'b1, step_q};
            addr_tgt_a_sec: rd_mux = {1'b1, tgt_a_sec_q};
            addr_tgt_a_ns: rd_mux = {1'b1, 2'b00, tgt_a_ns_q};
            addr_tgt_b_sec: rd_mux = {1'b1, tgt_b_sec_q};
            addr_tgt_b_ns: rd_mux = {1'b1, 2'b00, tgt_b_ns_q};
            default: rd_mux = {1'b0, 32'h00000000};
        endcase
    endfunction

    logic [32:0] rd_word;
    always_comb begin
        rd_word = rd_mux(rd_addr_q);
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            arready <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_addr_q <= 12'h000;
            rvalid <= 1'b0;
            rdata <= 32'h00000000;
            rresp <= resp_okay;
        end else begin
            arready <= 1'b0;
            if (arvalid && !rd_pend_q && !arready && !rvalid) begin
                arready <= 1'b1;
                rd_pend_q <= 1'b1;
                rd_addr_q <= araddr;
            end
            if (rd_pend_q && !rvalid) begin
                rd_pend_q <= 1'b0;
                rvalid <= 1'b1;
                if (rd_addr_q[11:7] == addr_cap_base[11:7]) begin
                    rdata <= rd_addr_q[2] ? cap_rd[31:0] : cap_rd[63:32];
                    rresp <= resp_okay;
                end else begin
                    rdata <= rd_word[31:0];
                    rresp <= rd_word[32] ? resp_okay : resp_slverr;
                end
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    sequence s_disable_cmd;
        wcmd[bit_disable] && !unit_rst && !strap_load_q;
    endsequence
    a_disable_blocks_start: assert property (@(posedge clock) disable iff (srst)
        s_disable_cmd |=> !frame_start_allow) else $error("frames allowed after disable");
    a_disable_waits_busy: assert property (@(posedge clock) disable iff (srst)
        dis_pend_q && frame_busy && unit_enabled && !unit_rst |=> unit_enabled)
        else $error("enable dropped while frames busy");
    a_reset_disables: assert property (@(posedge clock) disable iff (srst)
        unit_rst && !strap_load_q |=> !unit_enabled && unit_reset_pulse)
        else $error("unit reset left unit enabled");
    a_strap_enable: assert property (@(posedge clock)
        $fell(srst) |=> unit_enabled == $past(enable_strap)) else $error("strap not loaded");
    a_clock_read_hold: assert property (@(posedge clock) disable iff (srst)
        wcmd[bit_clock_read] && !unit_rst |=> sec_hold_q == $past(run_seconds)
        && subns_hold_q == $past(run_subnanoseconds)) else $error("clock snapshot wrong");
    a_target_copy: assert property (@(posedge clock) disable iff (srst)
        wcmd[bit_target_read] && !unit_rst |=> tgt_b_sec_q == $past(target_b_seconds))
        else $error("target snapshot wrong");
    a_capture_irq: assert property (@(posedge clock) disable iff (srst)
        cap_we && !unit_rst |=> irq_sts_q[$past(cap_sel_wr)]) else $error("capture irq missing");
    a_load_pulse: assert property (@(posedge clock) disable iff (srst)
        wcmd[bit_clock_load] && !unit_rst |=> load_pulse && load_seconds == $past(sec_hold_q))
        else $error("clock load missing");
endmodule

/* File: ptp_clock_command_control_bench.sv */
`timescale 1ns/1ps
module ptp_clock_command_control_bench;
    import ptp_cmd_pkg::*;
    logic clock = 0, srst = 1, enable_strap = 1, frame_busy = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq, temp_rate_active;
    logic frame_start_allow, unit_enabled, unit_reset_pulse, load_pulse;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, load_seconds, load_subnanoseconds, temp_rate_value;
    logic [29:0] load_nanoseconds;
    logic [31:0] run_seconds = 32'h12345678, run_subnanoseconds = 32'hA5A5A5A5;
    logic [29:0] run_nanoseconds = 30'h1000;
    logic [31:0] target_a_seconds = 32'hAA01, target_b_seconds = 32'hBB02;
    logic [29:0] target_a_nanoseconds = 30'hAA03, target_b_nanoseconds = 30'hBB04;
    logic [31:0] got, ls, lns, lsub, sts;
    int miscompares = 0, comparisons = 0, pulses = 0, rst_pulses = 0, temp_cycles = 0;

    ptp_clock_command_control u_dut (
        .clock(clock), .srst(srst), .enable_strap(enable_strap),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .run_seconds(run_seconds), .run_nanoseconds(run_nanoseconds),
        .run_subnanoseconds(run_subnanoseconds), .target_a_seconds(target_a_seconds),
        .target_a_nanoseconds(target_a_nanoseconds), .target_b_seconds(target_b_seconds),
        .target_b_nanoseconds(target_b_nanoseconds), .frame_busy(frame_busy),
        .frame_start_allow(frame_start_allow), .unit_enabled(unit_enabled),
        .unit_reset_pulse(unit_reset_pulse), .load_pulse(load_pulse),
        .load_seconds(load_seconds), .load_nanoseconds(load_nanoseconds),
        .load_subnanoseconds(load_subnanoseconds), .temp_rate_active(temp_rate_active),
        .temp_rate_value(temp_rate_value), .irq(irq)
    );

    always #12.5 clock = ~clock;

    // ----------------------------------------
    // pulse monitors and bus tasks
    // ----------------------------------------
    always @(posedge clock) begin
        if (load_pulse === 1'b1) begin
            pulses++;
            ls <= load_seconds;
            lns <= {2'h0, load_nanoseconds};
            lsub <= load_subnanoseconds;
        end
        if (unit_reset_pulse === 1'b1) rst_pulses++;
        if (temp_rate_active === 1'b1) temp_cycles++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clock);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clock);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        got = rdata;
        resp = rresp;
    endtask

    task automatic expect_rd(input logic [11:0] a, input logic [31:0] exp);
        rd(a);
        check(got, exp);
    endtask

    task automatic cmd(input logic [31:0] d);
        wr(addr_cmd_ctl, d);
        repeat (3) @(posedge clock);
    endtask

    task automatic results();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        expect_rd(addr_cmd_ctl, 32'h4);
        $display("reset test done");
        cmd(32'h8);
        run_seconds <= 32'h100;
        expect_rd(addr_clock_sec, 32'h12345678);
        expect_rd(addr_clock_ns, 32'h1000);
        expect_rd(addr_clock_subns, 32'hA5A5A5A5);
        wr(addr_clock_sec, 32'h777);
        cmd(32'h10);
        check(ls, 32'h777);
        check(lsub, 32'hA5A5A5A5);
        wr(addr_step_adj, 32'h200);
        cmd(32'h40);
        check(lns, 32'h1200);
        wr(addr_step_adj, 32'h80000005);
        cmd(32'h20);
        check(ls, 32'hFB);
        wr(addr_step_adj, 32'h5);
        cmd(32'h20);
        check(ls, 32'h105);
        check(pulses, 4);
        $display("clock test done");
        wr(addr_int_en, 32'hFFFF);
        sts = 0;
        for (int i = 0; i < 16; i++) begin
            run_seconds <= 32'h300 + i;
            cmd({19'h0, i[3:0], 9'h100});
            sts[i] = 1'b1;
            expect_rd(addr_int_sts, sts);
            expect_rd(addr_cap_base + 12'(i * 8), 32'h300 + i);
        end
        check(irq, 1);
        wr(addr_int_en, 32'h0);
        @(posedge clock);
        check(irq, 0);
        wr(addr_int_clr, 32'hFFFF);
        expect_rd(addr_int_sts, 32'h0);
        $display("capture test done");
        cmd(32'h2000);
        expect_rd(addr_tgt_a_sec, 32'hAA01);
        expect_rd(addr_tgt_a_ns, 32'hAA03);
        expect_rd(addr_tgt_b_sec, 32'hBB02);
        expect_rd(addr_tgt_b_ns, 32'hBB04);
        wr(addr_temp_rate, 32'h1234);
        wr(addr_temp_dur, 32'h5);
        cmd(32'h80);
        repeat (8) @(posedge clock);
        check(temp_cycles, 5);
        check(temp_rate_value, 32'h1234);
        $display("target and rate test done");
        frame_busy <= 1'b1;
        cmd(32'h2);
        check(frame_start_allow, 0);
        check(unit_enabled, 1);
        frame_busy <= 1'b0;
        repeat (4) @(posedge clock);
        check(unit_enabled, 0);
        cmd(32'h0);
        check(unit_enabled, 0);
        cmd(32'h4);
        check(unit_enabled, 1);
        cmd(32'h0);
        check(unit_enabled, 1);
        cmd(32'h2);
        expect_rd(addr_cmd_ctl, 32'h0);
        cmd(32'h1);
        check(rst_pulses, 1);
        check(unit_enabled, 0);
        expect_rd(addr_step_adj, 32'h0);
        $display("enable test done");
        expect_rd(12'hFF0, 32'h0);
        check(resp, resp_slverr);
        wr(12'hFF4, 32'h1);
        check(resp, resp_slverr);
        $display("unmapped test done");
        enable_strap <= 1'b0;
        srst <= 1'b1;
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        expect_rd(addr_cmd_ctl, 32'h0);
        $display("strap test done");
        results();
    end

    initial begin
        repeat (20000) @(posedge clock);
        miscompares++;
        results();
    end
endmodule

/* File: ptp_cmd_pkg.sv */
package ptp_cmd_pkg;
    // register byte addresses
    localparam logic [11:0] addr_cmd_ctl = 12'h100;
    localparam logic [11:0] addr_int_sts = 12'h108;
    localparam logic [11:0] addr_int_en = 12'h10C;
    localparam logic [11:0] addr_int_clr = 12'h1A0;
    localparam logic [11:0] addr_clock_sec = 12'h110;
    localparam logic [11:0] addr_clock_ns = 12'h114;
    localparam logic [11:0] addr_clock_subns = 12'h118;
    localparam logic [11:0] addr_temp_rate = 12'h120;
    localparam logic [11:0] addr_temp_dur = 12'h124;
    localparam logic [11:0] addr_step_adj = 12'h128;
    localparam logic [11:0] addr_tgt_a_sec = 12'h12C;
    localparam logic [11:0] addr_tgt_a_ns = 12'h130;
    localparam logic [11:0] addr_tgt_b_sec = 12'h13C;
    localparam logic [11:0] addr_tgt_b_ns = 12'h140;
    localparam logic [11:0] addr_cap_base = 12'h200;
    // command and control bit positions
    localparam int bit_reset = 0;
    localparam int bit_disable = 1;
    localparam int bit_enable = 2;
    localparam int bit_clock_read = 3;
    localparam int bit_clock_load = 4;
    localparam int bit_step_sec = 5;
    localparam int bit_step_ns = 6;
    localparam int bit_temp_rate = 7;
    localparam int bit_manual_cap = 8;
    localparam int sel_lo = 9;
    localparam int sel_hi = 12;
    localparam int bit_target_read = 13;
    // step adjust register layout
    localparam int step_dir_bit = 31;
    localparam int step_val_hi = 29;
    // interrupt status layout: bits 0..7 rising capture, 8..15 falling
    localparam int irq_width = 16;
    localparam int gpio_count = 8;
    localparam logic [3:0] sel_reset = 4'h0;
    localparam logic [31:0] ns_per_sec = 32'h3B9ACA00;
    localparam logic [1:0] resp_okay = 2'h0;
    localparam logic [1:0] resp_slverr = 2'h2;
endpackage
